// File: canmc_mode_ctrl.sv
// Operating-mode controller for all channels of one CAN controller unit
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module canmc_mode_ctrl
    import canmc_pkg::*;
(
    input wire logic clk_i, // Controller clock, 40 MHz
    input wire logic rst_i, // Synchronous reset, active high
    input wire logic [ADDR_W-1:0] addr_i, // Register byte address
    input wire logic [DATA_W-1:0] wdata_i, // Register write data
    input wire logic we_i, // Write strobe
    input wire logic re_i, // Read strobe
    output logic [DATA_W-1:0] rdata_o, // Read data, cycle after strobe
    input wire logic [NUM_CH-1:0] frame_active_i, // Frame in progress on bus
    input wire logic [NUM_CH-1:0] busoff_recovered_i, // Pulse: recovery done
    input wire logic [NUM_CH-1:0] bit_tick_i, // Pulse: one bit time
    input wire logic [NUM_CH-1:0] block_msg_sent_i, // Pulse: block message sent
    output logic [NUM_CH-1:0] soft_reset_o, // Channel in soft reset
    output logic [NUM_CH-1:0] bus_on_o, // Channel attached to bus
    output logic [NUM_CH-1:0] tx_en_o, // Transmission allowed
    output logic [NUM_CH-1:0] err_sig_en_o, // Error signalling allowed
    output logic [NUM_CH-1:0] ack_en_o, // Acknowledge allowed
    output logic [NUM_CH-1:0] loopback_o, // Internal loopback
    output logic [NUM_CH-1:0] fd_en_o, // FD frames
    output logic [NUM_CH-1:0] brs_en_o, // Bit rate switch
    output logic [NUM_CH-1:0] one_attempt_o, // No retransmission
    output logic [NUM_CH-1:0] block_tx_o, // Block transmission mode
    output logic [NUM_CH-1:0] block_gap_ok_o, // Next block message may go
    output logic [NUM_CH-1:0] err_clear_o, // Pulse: clear error counters
    output logic [NUM_CH-1:0] ts_load_o, // Pulse: load timestamp counter
    output logic [NUM_CH-1:0] wdt_load_o, // Pulse: load watchdog prescaler
    output logic [15:0] ts_value_o, // Timestamp load value
    output logic [15:0] wdt_value_o // Watchdog prescale value
);
    // ---------------------------------------------------------------
    // Software registers
    // ---------------------------------------------------------------
    logic [CMD_W-1:0] cmd_q;
    logic [15:0] ts_val_q;
    logic [15:0] wdt_val_q;
    logic [7:0] gap_exp_q;
    logic [7:0] clr_req_q;
    logic [DATA_W-1:0] rdata_q;

    logic cmd_wr;
    logic [MODE_W-1:0] new_mode;
    logic new_recover;
    logic new_is_init;
    logic cmd_ignored;
    logic new_silent;

    assign cmd_wr = we_i && (addr_i == ADDR_CMD);
    assign new_mode = wdata_i[MODE_W-1:0];
    assign new_recover = wdata_i[CMD_RECOVER_BIT];
    assign new_is_init = (new_mode[3:0] == MODE_INIT);
    // A zero timeout turns an init request into a no-op
    assign cmd_ignored = new_is_init && (wdt_val_q == 16'h0000);
    // Halt and init must not cut a frame short
    assign new_silent = (new_mode[3:0] == MODE_HALTED) || new_is_init;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_q <= '0;
        end else if (cmd_wr) begin
            cmd_q <= wdata_i[CMD_W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ts_val_q <= 16'h0000;
            wdt_val_q <= 16'h0000;
        end else if (we_i && (addr_i == ADDR_TIMING)) begin
            ts_val_q <= wdata_i[15:0];
            wdt_val_q <= wdata_i[31:16];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gap_exp_q <= 8'h00;
            clr_req_q <= 8'h00;
        end else if (we_i && (addr_i == ADDR_BLOCK)) begin
            gap_exp_q <= wdata_i[7:0];
            clr_req_q <= wdata_i[15:8];
        end
    end

    // Values ride with the load pulses
    assign ts_value_o = ts_val_q;
    assign wdt_value_o = wdt_val_q;

    // ---------------------------------------------------------------
    // Per-channel mode state
    // ---------------------------------------------------------------
    logic [NUM_CH*MODE_W-1:0] mode_flat;
    logic [NUM_CH-1:0] drain_flat;
    logic [NUM_CH-1:0] recov_flat;

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
            canmc_ch_state_t state_q;
            logic [MODE_W-1:0] mode_q;
            logic [MODE_W-1:0] pend_q;
            logic recov_q;
            logic hit;
            logic accept;
            logic talking;
            logic clr_q;
            logic ts_q;
            logic [9:0] dec;
            logic [9:0] en_q;

            // Selected directly, or through the global selector
            assign hit = cmd_wr && (wdata_i[CMD_GLOBAL_BIT]
                || (wdata_i[CMD_CHAN_BIT] == 1'(ch)));
            assign accept = hit && !cmd_ignored;
            assign talking = dec[1] || dec[5];

            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    state_q <= CH_STEADY;
                    mode_q <= MODE_RESET_VAL;
                    pend_q <= MODE_RESET_VAL;
                end else begin
                    case (state_q)
                        CH_STEADY: begin
                            if (accept) begin
                                if (new_silent && talking && frame_active_i[ch]) begin
                                    pend_q <= new_mode;
                                    state_q <= CH_DRAIN;
                                end else begin
                                    mode_q <= new_mode;
                                end
                            end
                        end
                        CH_DRAIN: begin
                            if (accept && !new_silent) begin
                                // Soft reset or a new running mode overrides the wait
                                mode_q <= new_mode;
                                state_q <= CH_STEADY;
                            end else if (accept) begin
                                pend_q <= new_mode;
                            end else if (!frame_active_i[ch]) begin
                                mode_q <= pend_q;
                                state_q <= CH_STEADY;
                            end
                        end
                        default: begin
                            state_q <= CH_STEADY;
                        end
                    endcase
                end
            end

            // Recovery wait flag; a new request wins over the clearing pulse
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    recov_q <= 1'b0;
                end else if (accept && new_recover) begin
                    recov_q <= 1'b1;
                end else if (busoff_recovered_i[ch]) begin
                    recov_q <= 1'b0;
                end
            end

            // Start side effects: load pulses on every accepted command, error clear only when requested
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    clr_q <= 1'b0;
                    ts_q <= 1'b0;
                end else begin
                    clr_q <= accept && (clr_req_q != 8'h00);
                    ts_q <= accept;
                end
            end

            canmc_mode_decode u_dec (
                .mode_i(mode_q),
                .soft_reset_o(dec[0]),
                .bus_on_o(dec[1]),
                .tx_en_o(dec[2]),
                .err_sig_en_o(dec[3]),
                .ack_en_o(dec[4]),
                .loopback_o(dec[5]),
                .fd_en_o(dec[6]),
                .brs_en_o(dec[7]),
                .one_attempt_o(dec[8]),
                .block_tx_o(dec[9])
            );

            // Enables are registered so the protocol core sees clean levels
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    en_q <= 10'h001;
                end else begin
                    en_q <= dec;
                end
            end

            canmc_gap_timer u_gap (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .enable_i(en_q[9]),
                .sent_i(block_msg_sent_i[ch]),
                .bit_tick_i(bit_tick_i[ch]),
                .exp_i(gap_exp_q),
                .ready_o(block_gap_ok_o[ch])
            );

            assign {block_tx_o[ch], one_attempt_o[ch], brs_en_o[ch], fd_en_o[ch], loopback_o[ch], ack_en_o[ch],
                err_sig_en_o[ch], tx_en_o[ch], bus_on_o[ch], soft_reset_o[ch]} = en_q;
            assign err_clear_o[ch] = clr_q;
            assign ts_load_o[ch] = ts_q;
            assign wdt_load_o[ch] = ts_q;
            assign mode_flat[ch*MODE_W +: MODE_W] = mode_q;
            assign drain_flat[ch] = (state_q == CH_DRAIN);
            assign recov_flat[ch] = recov_q;
        end
    endgenerate

    // ---------------------------------------------------------------
    // Read port
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i || !re_i) begin
            rdata_q <= '0;
        end else if (addr_i == ADDR_CMD) begin
            rdata_q <= DATA_W'(cmd_q);
        end else if (addr_i == ADDR_TIMING) begin
            rdata_q <= {wdt_val_q, ts_val_q};
        end else if (addr_i == ADDR_BLOCK) begin
            rdata_q <= {16'h0000, clr_req_q, gap_exp_q};
        end else if (addr_i == ADDR_STATUS) begin
            rdata_q <= {10'h000, block_gap_ok_o, recov_flat, drain_flat, mode_flat};
        end else begin
            rdata_q <= '0;
        end
    end

    assign rdata_o = rdata_q;
endmodule

// File: canmc_pkg.sv
// Constants, field layout and types for the CAN channel mode controller
// Notes on behaviour
// - Reset command enters configurable soft reset.
// - Init mode stops traffic, allows configuration.
// - Classical-only mode uses classical frames only.
// - FD without switching never uses fast data rate.
// - FD with switching applies the data-phase rate.
// - Block transmit mode is normal plus block sending.
// - Block gap is two to (5+setting) bits.
// - Listen-only: receive, no transmit, error flag, ack.
// - One-attempt mode never retransmits lost frames.
// - Self-test loops frames back, bus detached.
// - Restricted: no transmit or error flags, still acks.
// - Listen, self-test, one-attempt, restricted OR into mode.
// - Clear request zeroes both error counters.
// - Start loads timestamp counter.
// - Start loads watchdog prescaler.
// - Init request with zero timeout changes nothing.
// - Global selector commands every channel.
// - Halt stops bus traffic without soft reset.
// - Init waits for frame end, then silent.
package canmc_pkg;
    localparam int NUM_CH = 2;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int MODE_W = 8;

    // ---------------------------------------------------------------
    // Register offsets
    // ---------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_CMD = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_TIMING = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_BLOCK = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h0C;

    // ---------------------------------------------------------------
    // Command word fields
    // ---------------------------------------------------------------
    localparam int CMD_RECOVER_BIT = 8;
    localparam int CMD_CHAN_BIT = 9;
    localparam int CMD_GLOBAL_BIT = 10;
    localparam int CMD_W = 11;

    // Base mode codes in the low nibble of the mode byte
    localparam logic [3:0] MODE_SOFT_RESET = 4'h0;
    localparam logic [3:0] MODE_HALTED = 4'h1;
    localparam logic [3:0] MODE_INIT = 4'h2;
    localparam logic [3:0] MODE_NORMAL = 4'h3;
    localparam logic [3:0] MODE_CLASSICAL = 4'h4;
    localparam logic [3:0] MODE_FD_NO_SWITCH = 4'h5;
    localparam logic [3:0] MODE_FD_RATE_SWITCH = 4'h6;
    localparam logic [3:0] MODE_BLOCK_TX = 4'h7;

    // Option bits in the high nibble of the mode byte
    localparam int OPT_LISTEN_BIT = 4;
    localparam int OPT_SELFTEST_BIT = 5;
    localparam int OPT_ONE_ATTEMPT_BIT = 6;
    localparam int OPT_RESTRICT_BIT = 7;

    localparam logic [MODE_W-1:0] MODE_RESET_VAL = 8'h00;

    // ---------------------------------------------------------------
    // Block gap timing
    // ---------------------------------------------------------------
    localparam logic [4:0] GAP_BASE_EXP = 5'h05;
    localparam logic [7:0] GAP_EXP_MAX = 8'h0F;
    localparam int GAP_CNT_W = 21;

    typedef enum logic [1:0] {
        CH_STEADY = 2'b00,
        CH_DRAIN = 2'b01
    } canmc_ch_state_t;
endpackage

// File: canmc_mode_decode.sv
// Decodes an active mode byte into the channel's protocol enables
`timescale 1ns/1ps
module canmc_mode_decode
    import canmc_pkg::*;
(
    input wire logic [MODE_W-1:0] mode_i, // Active mode byte
    output logic soft_reset_o, // Channel held in soft reset
    output logic bus_on_o, // Channel attached to the external bus
    output logic tx_en_o, // Frames may be transmitted
    output logic err_sig_en_o, // Error frames may be signalled
    output logic ack_en_o, // Acknowledge slots may be driven
    output logic loopback_o, // Own frames received internally
    output logic fd_en_o, // FD frames exchanged
    output logic brs_en_o, // Data-phase rate switch used
    output logic one_attempt_o, // No automatic retransmission
    output logic block_tx_o // Block transmission active
);
    logic [3:0] base;
    logic run;
    logic listen;
    logic selftest;
    logic restrict_opt;

    always_comb begin
        base = mode_i[3:0];
        listen = mode_i[OPT_LISTEN_BIT];
        selftest = mode_i[OPT_SELFTEST_BIT];
        restrict_opt = mode_i[OPT_RESTRICT_BIT];
        // Halt, init and unknown codes keep the channel silent
        run = (base >= MODE_NORMAL) && (base <= MODE_BLOCK_TX);
        soft_reset_o = (base == MODE_SOFT_RESET);
        bus_on_o = run && !selftest;
        tx_en_o = run && !listen && !restrict_opt;
        err_sig_en_o = run && !listen && !restrict_opt;
        ack_en_o = run && !listen;
        loopback_o = run && selftest;
        fd_en_o = (base == MODE_FD_NO_SWITCH) || (base == MODE_FD_RATE_SWITCH);
        brs_en_o = (base == MODE_FD_RATE_SWITCH);
        one_attempt_o = run && mode_i[OPT_ONE_ATTEMPT_BIT];
        block_tx_o = (base == MODE_BLOCK_TX);
    end
endmodule

// File: canmc_gap_timer.sv
// Spacing timer between consecutive block-transmission messages
`timescale 1ns/1ps
module canmc_gap_timer
    import canmc_pkg::*;
(
    input wire logic clk_i, // Controller clock
    input wire logic rst_i, // Synchronous reset, active high
    input wire logic enable_i, // Block transmission mode active
    input wire logic sent_i, // Pulse: a block message finished
    input wire logic bit_tick_i, // Pulse: one CAN bit time elapsed
    input wire logic [7:0] exp_i, // Gap exponent setting
    output logic ready_o // Next block message may start
);
    logic [GAP_CNT_W-1:0] cnt_q;
    logic busy_q;
    logic [4:0] shift;
    logic [GAP_CNT_W-1:0] last;

    // Settings above the maximum saturate so the counter never wraps
    always_comb begin
        shift = GAP_BASE_EXP + ((exp_i > GAP_EXP_MAX) ? GAP_EXP_MAX[4:0] : exp_i[4:0]);
        last = (GAP_CNT_W'(1) << shift) - GAP_CNT_W'(1);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || !enable_i) begin
            busy_q <= 1'b0;
            cnt_q <= '0;
        end else if (sent_i) begin
            busy_q <= 1'b1;
            cnt_q <= '0;
        end else if (busy_q && bit_tick_i) begin
            if (cnt_q == last) begin
                busy_q <= 1'b0;
            end else begin
                cnt_q <= cnt_q + GAP_CNT_W'(1);
            end
        end
    end

    assign ready_o = !busy_q;
endmodule

// File: canmc_mode_ctrl_sva.sv
// Port assertions for the mode controller
`timescale 1ns/1ps
module canmc_mode_ctrl_sva
    import canmc_pkg::*;
(
    input wire logic clk_i, // clock
    input wire logic rst_i, // reset
    input wire logic [ADDR_W-1:0] addr_i, // address
    input wire logic [DATA_W-1:0] wdata_i, // write data
    input wire logic we_i, // write strobe
    input wire logic re_i, // read strobe
    input wire logic [DATA_W-1:0] rdata_o, // read data
    input wire logic [NUM_CH-1:0] block_msg_sent_i, // block sent
    input wire logic [NUM_CH-1:0] soft_reset_o, // soft reset
    input wire logic [NUM_CH-1:0] bus_on_o, // on bus
    input wire logic [NUM_CH-1:0] tx_en_o, // transmit
    input wire logic [NUM_CH-1:0] err_sig_en_o, // error flag
    input wire logic [NUM_CH-1:0] ack_en_o, // acknowledge
    input wire logic [NUM_CH-1:0] loopback_o, // loopback
    input wire logic [NUM_CH-1:0] fd_en_o, // fd frames
    input wire logic [NUM_CH-1:0] brs_en_o, // rate switch
    input wire logic [NUM_CH-1:0] block_tx_o, // block mode
    input wire logic [NUM_CH-1:0] block_gap_ok_o, // gap over
    input wire logic [NUM_CH-1:0] ts_load_o, // load pulse
    input wire logic [15:0] wdt_value_o // prescale value
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_read_idle_zero: assert property (!$past(re_i) |-> rdata_o == '0)
        else $error("read data not idle");
    a_soft_reset_quiet: assert property ((soft_reset_o & (bus_on_o | tx_en_o | ack_en_o)) == '0)
        else $error("active in soft reset");
    a_brs_needs_fd: assert property ((brs_en_o & ~fd_en_o) == '0)
        else $error("rate switch without fd");
    a_selftest_detached: assert property ((loopback_o & bus_on_o) == '0)
        else $error("loopback on bus");
    a_tx_err_ack: assert property (((tx_en_o ^ err_sig_en_o) | (tx_en_o & ~ack_en_o)) == '0)
        else $error("tx, error and ack enables disagree");
    a_load_from_cmd: assert property (ts_load_o[0] |-> $past(we_i) && $past(addr_i) == ADDR_CMD &&
        ($past(wdata_i[CMD_GLOBAL_BIT]) || !$past(wdata_i[CMD_CHAN_BIT])))
        else $error("load pulse without command");
    a_init_zero_ignored: assert property (we_i && addr_i == ADDR_CMD && wdata_i[3:0] == MODE_INIT &&
        wdt_value_o == 16'h0000 |=> ts_load_o == '0)
        else $error("init command taken with zero timeout");
    a_soft_cmd_latency: assert property (we_i && addr_i == ADDR_CMD && wdata_i[CMD_GLOBAL_BIT] &&
        wdata_i[3:0] == MODE_SOFT_RESET |=> ##1 soft_reset_o == '1)
        else $error("soft reset late");
    a_gap_start: assert property (block_msg_sent_i[0] && block_tx_o[0] |=> !block_gap_ok_o[0])
        else $error("gap not started");
    a_gap_min_hold: assert property ($fell(block_gap_ok_o[0]) |-> !block_gap_ok_o[0] [*8])
        else $error("gap too short");
endmodule

bind canmc_mode_ctrl canmc_mode_ctrl_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .block_msg_sent_i(block_msg_sent_i),
    .soft_reset_o(soft_reset_o), .bus_on_o(bus_on_o), .tx_en_o(tx_en_o), .err_sig_en_o(err_sig_en_o),
    .ack_en_o(ack_en_o), .loopback_o(loopback_o), .fd_en_o(fd_en_o), .brs_en_o(brs_en_o),
    .block_tx_o(block_tx_o), .block_gap_ok_o(block_gap_ok_o), .ts_load_o(ts_load_o),
    .wdt_value_o(wdt_value_o));

// File: canmc_bus_model.sv
// Behavioural model of the CAN bus side of the channels
`timescale 1ns/1ps
module canmc_bus_model
    import canmc_pkg::*;
#(
    parameter int TICK_DIV = 4,
    parameter int FRAME_LEN = 24
)
(
    input wire logic clk_i, // clock
    input wire logic rst_i, // reset
    input wire logic [NUM_CH-1:0] bus_on_i, // channel on bus
    input wire logic [NUM_CH-1:0] block_tx_i, // block mode
    input wire logic [NUM_CH-1:0] frame_go_i, // start a frame
    input wire logic [NUM_CH-1:0] sent_go_i, // end a block message
    input wire logic [NUM_CH-1:0] recover_go_i, // end bus-off
    output logic [NUM_CH-1:0] frame_active_o, // frame on bus
    output logic [NUM_CH-1:0] busoff_recovered_o, // recovery pulse
    output logic [NUM_CH-1:0] bit_tick_o, // bit time pulse
    output logic [NUM_CH-1:0] block_msg_sent_o // block sent pulse
);
    int div_q;
    int frm_q[NUM_CH];
    logic [NUM_CH-1:0] pend_q;
    // A message ends just after a bit boundary, never on the tick itself
    always_ff @(posedge clk_i) begin
        div_q <= (rst_i || div_q == TICK_DIV - 1) ? 0 : div_q + 1;
        bit_tick_o <= rst_i ? '0 : {NUM_CH{div_q == TICK_DIV - 1}};
        busoff_recovered_o <= rst_i ? '0 : recover_go_i;
        block_msg_sent_o <= (!rst_i && div_q == 0) ? (pend_q & block_tx_i) : '0;
        pend_q <= rst_i ? '0 : ((div_q == 0 ? '0 : pend_q) | sent_go_i);
        for (int n = 0; n < NUM_CH; n++) begin
            // Frames only start while the channel is attached
            if (rst_i) begin
                frm_q[n] <= 0;
            end else if (frame_go_i[n] && bus_on_i[n]) begin
                frm_q[n] <= FRAME_LEN;
            end else if (frm_q[n] != 0) begin
                frm_q[n] <= frm_q[n] - 1;
            end
        end
    end
    always_comb begin
        for (int n = 0; n < NUM_CH; n++) begin
            frame_active_o[n] = frm_q[n] != 0;
        end
    end
endmodule

// File: tb_top.sv
// Self-checking bench for the CAN channel mode controller
`timescale 1ns/1ps
module tb_top;
    import canmc_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [ADDR_W-1:0] addr_i = '0;
    logic [DATA_W-1:0] wdata_i = '0;
    logic we_i = 1'b0;
    logic re_i = 1'b0;
    logic [NUM_CH-1:0] frame_go = '0, sent_go = '0, rec_go = '0;
    logic [NUM_CH-1:0] fa, br, bt, bs, sr, bo, tx, er, ak, lb, fd, brs, oa, bk, gap, ec, tl, wl;
    logic [DATA_W-1:0] rdata_o;
    logic [15:0] tsv, wdv;
    logic [DATA_W-1:0] exp_q[$];
    logic rd_wait = 1'b0;
    logic [7:0] md_e[NUM_CH] = '{8'h00, 8'h00};
    logic [1:0] drn_e = 2'b00, rec_e = 2'b00;
    logic [15:0] wdt_e = 16'h0000;
    logic [31:0] rng = 32'h0000000E;
    int error_cnt = 0, checked = 0, cyc = 0, cnt;
    localparam logic [7:0] MODES[13] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
        8'h07, 8'h09, 8'h13, 8'h23, 8'h43, 8'h83};

    always #12.5 clk_i = ~clk_i;

    canmc_mode_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
        .re_i(re_i), .rdata_o(rdata_o), .frame_active_i(fa), .busoff_recovered_i(br), .bit_tick_i(bt),
        .block_msg_sent_i(bs), .soft_reset_o(sr), .bus_on_o(bo), .tx_en_o(tx), .err_sig_en_o(er),
        .ack_en_o(ak), .loopback_o(lb), .fd_en_o(fd), .brs_en_o(brs), .one_attempt_o(oa),
        .block_tx_o(bk), .block_gap_ok_o(gap), .err_clear_o(ec), .ts_load_o(tl), .wdt_load_o(wl),
        .ts_value_o(tsv), .wdt_value_o(wdv));
    canmc_bus_model bus (.clk_i(clk_i), .rst_i(rst_i), .bus_on_i(bo), .block_tx_i(bk),
        .frame_go_i(frame_go), .sent_go_i(sent_go), .recover_go_i(rec_go), .frame_active_o(fa),
        .busoff_recovered_o(br), .bit_tick_o(bt), .block_msg_sent_o(bs));

    // ----
    // Helpers
    // ----
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    function automatic logic [9:0] dec(input logic [7:0] m);
        logic on;
        on = m[3:0] >= MODE_NORMAL && m[3:0] <= MODE_BLOCK_TX;
        return {m[3:0] == MODE_SOFT_RESET, on & ~m[5], on & ~m[4] & ~m[7], on & ~m[4] & ~m[7],
            on & ~m[4], on & m[5], m[3:0] == MODE_FD_NO_SWITCH || m[3:0] == MODE_FD_RATE_SWITCH,
            m[3:0] == MODE_FD_RATE_SWITCH, on & m[6], m[3:0] == MODE_BLOCK_TX};
    endfunction
    function automatic logic [31:0] status();
        return {10'h000, 2'b11, rec_e, drn_e, md_e[1], md_e[0]};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        we_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        we_i <= 1'b0;
    endtask
    task automatic pulse(input logic [5:0] v);
        @(posedge clk_i);
        {sent_go, rec_go, frame_go} <= v;
        @(posedge clk_i);
        {sent_go, rec_go, frame_go} <= '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_i);
        re_i <= 1'b1;
        addr_i <= a;
        exp_q.push_back(e);
        @(posedge clk_i);
        re_i <= 1'b0;
    endtask
    task automatic cmd(input logic [10:0] w, input logic clr);
        logic [1:0] sel;
        logic acc;
        sel = w[CMD_GLOBAL_BIT] ? 2'b11 : (w[CMD_CHAN_BIT] ? 2'b10 : 2'b01);
        acc = !(w[3:0] == MODE_INIT && wdt_e == 16'h0000);
        wr(ADDR_CMD, {21'h0, w});
        #1;
        check(tl, acc ? sel : 2'b00);
        check(wl, acc ? sel : 2'b00);
        check(ec, (acc && clr) ? sel : 2'b00);
        for (int n = 0; n < NUM_CH; n++) begin
            if (acc && sel[n]) md_e[n] = w[7:0];
        end
        if (acc && w[CMD_RECOVER_BIT]) rec_e = rec_e | sel;
        @(posedge clk_i);
        #1;
    endtask
    task automatic chk_en();
        logic [9:0] mk, got;
        for (int n = 0; n < NUM_CH; n++) begin
            mk = (md_e[n][3:0] == MODE_NORMAL || md_e[n][3:0] == MODE_BLOCK_TX) ? 10'h3F7 : 10'h3FF;
            got = {sr[n], bo[n], tx[n], er[n], ak[n], lb[n], fd[n], brs[n], oa[n], bk[n]};
            check(got & mk, dec(md_e[n]) & mk);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ----
    // Read monitor and run limit
    // ----
    always @(negedge clk_i) begin
        if (rd_wait) check(rdata_o, exp_q.pop_front());
        rd_wait = re_i;
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            $display("ERROR %0t: run did not finish", $time);
            tally_and_finish();
        end
    end

    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        chk_en();
        rd(ADDR_STATUS, status());
        rng = xs(rng);
        wdt_e = rng[31:16] | 16'h0001;
        wr(ADDR_TIMING, {wdt_e, rng[15:0]});
        #1;
        check(tsv, rng[15:0]);
        check(wdv, wdt_e);
        wr(ADDR_BLOCK, 32'h00000100);
        foreach (MODES[i]) begin
            cmd({3'b100, MODES[i]}, 1'b1);
            chk_en();
            rd(ADDR_STATUS, status());
        end
        wr(ADDR_BLOCK, 32'h00000000);
        cmd(11'h403, 1'b0);
        wr(ADDR_TIMING, {16'h0000, rng[15:0]});
        wdt_e = 16'h0000;
        cmd(11'h402, 1'b0);
        chk_en();
        rng = xs(rng);
        wdt_e = rng[31:16] | 16'h0001;
        wr(ADDR_TIMING, {wdt_e, rng[15:0]});
        cmd(11'h400, 1'b0);
        cmd(11'h203, 1'b0);
        cmd(11'h005, 1'b0);
        chk_en();
        rd(ADDR_CMD, 32'h00000005);
        rd(8'h10, 32'h00000000);
        pulse(6'h01);
        cmd(11'h401, 1'b0);
        md_e[0] = 8'h05;
        drn_e = 2'b01;
        chk_en();
        rd(ADDR_STATUS, status());
        #1;
        for (int i = 0; i < 100 && fa[0] !== 1'b0; i++) begin
            @(posedge clk_i);
            #1;
        end
        md_e[0] = 8'h01;
        drn_e = 2'b00;
        repeat (2) @(posedge clk_i);
        #1;
        chk_en();
        rd(ADDR_STATUS, status());
        cmd(11'h503, 1'b0);
        rd(ADDR_STATUS, status());
        pulse(6'h04);
        for (int i = 0; i < 10 && br[0] !== 1'b1; i++) @(posedge clk_i);
        @(posedge clk_i);
        rec_e = 2'b10;
        rd(ADDR_STATUS, status());
        for (int x = 0; x < 2; x++) begin
            wr(ADDR_BLOCK, x);
            cmd(11'h407, 1'b0);
            pulse(6'h10);
            #1;
            for (int i = 0; i < 20 && gap[0] !== 1'b0; i++) begin
                @(posedge clk_i);
                #1;
            end
            cnt = 0;
            for (int i = 0; i < 400 && gap[0] !== 1'b1; i++) begin
                if (bt[0] === 1'b1) cnt++;
                @(posedge clk_i);
                #1;
            end
            check(cnt, 32'd1 << (5 + x));
        end
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        md_e = '{8'h00, 8'h00};
        rec_e = 2'b00;
        @(posedge clk_i);
        #1;
        chk_en();
        rd(ADDR_STATUS, status());
        repeat (3) @(posedge clk_i);
        tally_and_finish();
    end
endmodule
